/* hdl/cspic_top.sv */
// Function
// - Two sockets, indexed and 800h alias access
// - Power bit 7 gates card outputs
// - Standard layout bit 6 reads zero
// - Standard bit 5 enables card-detect power switching
// - Standard bit 4 enables Vcc, level externally
// - Standard bits 3..2 read zero
// - Bits 1..0 request Vpp level
// - Vpp ignored while Vcc off
// - Alternate bits 4..3 request Vcc level
// - Alternate bits 6..5 and 2 read zero
// - Revision field 0010b selects standard layout
// - Power status shows Vcc on only
// - Control bit 7 enables ring indicate
// - Control bit 6 zero holds card reset
// - Control bit 5 selects memory or I/O
// - Bit 4 routes status change to PCI
// - Select zero also routes status change PCI
// - Select code picks IRQ line or SMI
`timescale 1ns/100ps
module cspic_top
    import cspic_pkg::*;
#(
    parameter int unsigned SOCKETS = CSPIC_SOCKETS
)
(
    input  wire logic                   mclk_in,
    input  wire logic                   rst_n_in,
    input  wire cspic_bus_req_type      bus_req_in,
    input  wire logic [3:0]             compat_revision_field_in,
    input  wire logic [SOCKETS-1:0]     system_power_select_in,
    input  wire logic [SOCKETS-1:0]     card_detect_in,
    input  wire logic [SOCKETS-1:0]     battery_detect_ring_in,
    input  wire logic [SOCKETS-1:0]     card_irq_in,
    input  wire logic [SOCKETS-1:0]     status_change_irq_in,
    input  wire logic [4*SOCKETS-1:0]   status_change_line_select_in,
    output logic      [7:0]             rd_data_out,
    output logic                        rd_valid_out,
    output logic      [SOCKETS-1:0]     card_output_enable_out,
    output logic      [SOCKETS-1:0]     auto_power_switch_en_out,
    output logic      [SOCKETS-1:0]     socket_vcc_enable_out,
    output logic      [2*SOCKETS-1:0]   vcc_level_out,
    output logic      [2*SOCKETS-1:0]   vpp_level_out,
    output logic      [SOCKETS-1:0]     socket_power_status_out,
    output logic      [SOCKETS-1:0]     card_reset_out,
    output logic      [SOCKETS-1:0]     card_reset_oe_n_out,
    output logic      [SOCKETS-1:0]     ring_indicate_out,
    output logic      [SOCKETS-1:0]     card_kind_select_out,
    output logic                        pci_irq_out,
    output logic      [15:0]            isa_irq_out,
    output logic                        smi_out
);

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------

    // Hit on the indexed window or on the memory-mapped alias
    function automatic logic index_hit(input logic [11:0] addr, input logic [7:0] idx);
        return (addr == {4'h0, idx}) || (addr == (CSPIC_ALIAS_BASE | {4'h0, idx}));
    endfunction

    wire std_mode = (compat_revision_field_in == CSPIC_REV_STANDARD);

    logic [SOCKETS-1:0] hit_power;
    logic [SOCKETS-1:0] hit_ctrl;
    logic [7:0]         power_rd_w [SOCKETS];
    logic [7:0]         ctrl_rd_w  [SOCKETS];
    cspic_supply_type   supply_w   [SOCKETS];
    cspic_ctrl_type     ctrl_w     [SOCKETS];
    logic [SOCKETS-1:0] pci_w;
    logic [15:0]        isa_w      [SOCKETS];
    logic [SOCKETS-1:0] smi_w;

    // ----------------------------------------------------------------
    // Per-socket register pairs and routing
    // ----------------------------------------------------------------
    genvar s;
    generate
        for (s = 0; s < SOCKETS; s++) begin : g_sock
            // Socket B sits one stride above socket A
            localparam logic [7:0] BASE = 8'(s * CSPIC_SOCK_STRIDE);
            assign hit_power[s] = index_hit(bus_req_in.addr, BASE + CSPIC_IDX_POWER);
            assign hit_ctrl[s]  = index_hit(bus_req_in.addr, BASE + CSPIC_IDX_CTRL);

            cspic_sock_regs u_regs (
                .mclk_in          (mclk_in),
                .rst_n_in         (rst_n_in),
                .wr_power_in      (bus_req_in.wr & hit_power[s]),
                .wr_ctrl_in       (bus_req_in.wr & hit_ctrl[s]),
                .wdata_in         (bus_req_in.wdata),
                .std_mode_in      (std_mode),
                .sys_power_sel_in (system_power_select_in[s]),
                .card_detect_in   (card_detect_in[s]),
                .power_rd_out     (power_rd_w[s]),
                .ctrl_rd_out      (ctrl_rd_w[s]),
                .supply_out       (supply_w[s]),
                .ctrl_out         (ctrl_w[s])
            );

            cspic_irq_route u_route (
                .ctrl_in          (ctrl_w[s]),
                .csc_line_sel_in  (status_change_line_select_in[4*s +: 4]),
                .card_irq_in      (card_irq_in[s]),
                .csc_irq_in       (status_change_irq_in[s]),
                .pci_irq_out      (pci_w[s]),
                .isa_irq_out      (isa_w[s]),
                .smi_out          (smi_w[s])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------

    // Unmapped addresses read as zero; read data is held until the next read
    logic [7:0] rd_sel;
    always_comb begin
        rd_sel = 8'h00;
        for (int i = 0; i < SOCKETS; i++) begin
            if (hit_power[i]) begin
                rd_sel = power_rd_w[i];
            end
            if (hit_ctrl[i]) begin
                rd_sel = ctrl_rd_w[i];
            end
        end
    end

    logic [7:0] rd_data_reg;
    logic       rd_valid_reg;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            rd_data_reg  <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= bus_req_in.rd;
            if (bus_req_in.rd) begin
                rd_data_reg <= rd_sel;
            end
        end
    end

    assign rd_data_out  = rd_data_reg;
    assign rd_valid_out = rd_valid_reg;

    // ----------------------------------------------------------------
    // Card-side outputs
    // ----------------------------------------------------------------

    // Combined interrupt lines; every socket may share a legacy line
    logic        pci_comb;
    logic [15:0] isa_comb;
    logic        smi_comb;
    always_comb begin
        pci_comb = |pci_w;
        smi_comb = |smi_w;
        isa_comb = 16'h0000;
        for (int i = 0; i < SOCKETS; i++) begin
            isa_comb = isa_comb | isa_w[i];
        end
    end

    logic [SOCKETS-1:0]   coe_next;
    logic [SOCKETS-1:0]   auto_next;
    logic [SOCKETS-1:0]   vcc_next;
    logic [2*SOCKETS-1:0] vcc_lvl_next;
    logic [2*SOCKETS-1:0] vpp_lvl_next;
    logic [SOCKETS-1:0]   rst_next;
    logic [SOCKETS-1:0]   ring_next;
    logic [SOCKETS-1:0]   kind_next;

    // Flatten socket decodes to output form
    always_comb begin
        for (int i = 0; i < SOCKETS; i++) begin
            coe_next[i]           = supply_w[i].card_output_enable;
            auto_next[i]          = supply_w[i].auto_sw;
            vcc_next[i]           = supply_w[i].vcc_on;
            vcc_lvl_next[2*i +: 2] = supply_w[i].vcc_level;
            vpp_lvl_next[2*i +: 2] = supply_w[i].vpp_level;
            rst_next[i]           = ~ctrl_w[i].card_run;
            // Ring only means something for an I/O card
            ring_next[i]          = ctrl_w[i].ring_en & ctrl_w[i].io_card
                                    & battery_detect_ring_in[i];
            kind_next[i]          = ctrl_w[i].io_card;
        end
    end

    logic [SOCKETS-1:0]   coe_reg;
    logic [SOCKETS-1:0]   auto_reg;
    logic [SOCKETS-1:0]   vcc_reg;
    logic [2*SOCKETS-1:0] vcc_lvl_reg;
    logic [2*SOCKETS-1:0] vpp_lvl_reg;
    logic [SOCKETS-1:0]   rst_reg;
    logic [SOCKETS-1:0]   ring_reg;
    logic [SOCKETS-1:0]   kind_reg;
    logic                 pci_reg;
    logic [15:0]          isa_reg;
    logic                 smi_reg;

    // Output flops; reset holds the card in reset with supplies off
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            coe_reg     <= '0;
            auto_reg    <= '0;
            vcc_reg     <= '0;
            vcc_lvl_reg <= '0;
            vpp_lvl_reg <= '0;
            rst_reg     <= '1;
            ring_reg    <= '0;
            kind_reg    <= '0;
            pci_reg     <= 1'b0;
            isa_reg     <= 16'h0000;
            smi_reg     <= 1'b0;
        end else begin
            coe_reg     <= coe_next;
            auto_reg    <= auto_next;
            vcc_reg     <= vcc_next;
            vcc_lvl_reg <= vcc_lvl_next;
            vpp_lvl_reg <= vpp_lvl_next;
            rst_reg     <= rst_next;
            ring_reg    <= ring_next;
            kind_reg    <= kind_next;
            pci_reg     <= pci_comb;
            isa_reg     <= isa_comb;
            smi_reg     <= smi_comb;
        end
    end

    assign card_output_enable_out   = coe_reg;
    assign auto_power_switch_en_out = auto_reg;
    assign socket_vcc_enable_out    = vcc_reg;
    assign vcc_level_out            = vcc_lvl_reg;
    assign vpp_level_out            = vpp_lvl_reg;
    assign socket_power_status_out  = vcc_reg;
    assign card_reset_out           = rst_reg;
    assign card_reset_oe_n_out      = ~coe_reg;
    assign ring_indicate_out        = ring_reg;
    assign card_kind_select_out     = kind_reg;
    assign pci_irq_out              = pci_reg;
    assign isa_irq_out              = isa_reg;
    assign smi_out                  = smi_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    wire wr_pa = bus_req_in.wr && index_hit(bus_req_in.addr, CSPIC_IDX_POWER);
    wire wr_ca = bus_req_in.wr && index_hit(bus_req_in.addr, CSPIC_IDX_CTRL);
    wire rd_pa = bus_req_in.rd && index_hit(bus_req_in.addr, CSPIC_IDX_POWER);

    coe_follows_a: assert property (wr_pa |=> ##1
        card_output_enable_out[0] == $past(bus_req_in.wdata[7], 2))
        else $error("card output enable does not follow power bit 7");

    alias_sock_b_a: assert property (
        bus_req_in.wr && bus_req_in.addr == 12'h0842 |=> ##1
        card_output_enable_out[1] == $past(bus_req_in.wdata[7], 2))
        else $error("socket B alias write did not reach socket B");

    std_reserved_a: assert property (rd_pa && std_mode |=>
        rd_valid_out && rd_data_out[6] == 1'b0 && rd_data_out[3:2] == 2'b00)
        else $error("standard layout reserved bits read nonzero");

    alt_reserved_a: assert property (rd_pa && !std_mode |=>
        rd_data_out[6:5] == 2'b00 && rd_data_out[2] == 1'b0)
        else $error("alternate layout reserved bits read nonzero");

    vpp_gated_a: assert property (
        vpp_level_out[1:0] != CSPIC_VPP_NONE |-> socket_vcc_enable_out[0])
        else $error("Vpp applied while Vcc is off");

    vpp_reserved_a: assert property (
        vpp_level_out[1:0] != 2'h3 && vcc_level_out[1:0] != 2'h3)
        else $error("reserved supply code reached the outputs");

    auto_switch_a: assert property (
        std_mode && supply_w[0].auto_sw && !card_detect_in[0] |=> !socket_vcc_enable_out[0])
        else $error("auto switching powered an empty socket");

    std_vcc_a: assert property (
        std_mode && card_detect_in[0] && wr_pa && bus_req_in.wdata[5:4] == 2'b01
        ##1 !wr_pa |=> socket_vcc_enable_out[0])
        else $error("standard Vcc enable bit not honoured");

    alt_vcc_a: assert property (
        !std_mode && wr_pa && bus_req_in.wdata[4:3] == 2'b01 ##1 !wr_pa
        |=> !socket_vcc_enable_out[0])
        else $error("alternate reserved Vcc code turned Vcc on");

    power_status_a: assert property (
        socket_power_status_out == socket_vcc_enable_out)
        else $error("power status disagrees with Vcc state");

    card_reset_a: assert property (wr_ca |=> ##1
        card_reset_out[0] == !$past(bus_req_in.wdata[6], 2))
        else $error("card reset does not follow control bit 6");

    card_kind_a: assert property (wr_ca |=> ##1
        card_kind_select_out[0] == $past(bus_req_in.wdata[5], 2))
        else $error("card kind does not follow control bit 5");

    ring_gate_a: assert property (
        !ctrl_w[0].ring_en |=> !ring_indicate_out[0])
        else $error("ring indicate passed while disabled");

    csc_pci_a: assert property (
        status_change_irq_in == 2'b01 &&
        (ctrl_w[0].csc_pci || ctrl_w[0].irq_sel == CSPIC_IRQ_NONE) |=> pci_irq_out)
        else $error("status change not routed to PCI");

    func_line_a: assert property (
        card_irq_in[0] && ctrl_w[0].io_card && ctrl_w[0].irq_sel == 4'h5 |=> isa_irq_out[5])
        else $error("functional interrupt missed its line");

    func_smi_a: assert property (
        card_irq_in[0] && ctrl_w[0].io_card && ctrl_w[0].irq_sel == CSPIC_IRQ_SMI
        |=> smi_out && isa_irq_out[2] == 1'b0)
        else $error("SMI code did not select SMI");

    cov_vcc_on_c:   cover property (socket_vcc_enable_out[0] && vpp_level_out[1:0] == 2'h2);
    cov_release_c:  cover property ($fell(card_reset_out[0]));
    cov_func_irq_c: cover property (card_irq_in[0] ##1 |isa_irq_out);
    cov_alt_mode_c: cover property (!std_mode && socket_vcc_enable_out[0]);

endmodule

/* inc/cspic_pkg.sv */
package cspic_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int unsigned CSPIC_SOCKETS      = 2;
    localparam logic [7:0]  CSPIC_IDX_POWER    = 8'h02;
    localparam logic [7:0]  CSPIC_IDX_CTRL     = 8'h03;
    localparam logic [7:0]  CSPIC_SOCK_STRIDE  = 8'h40;
    localparam logic [11:0] CSPIC_ALIAS_BASE   = 12'h0800;
    localparam logic [7:0]  CSPIC_RESET_VALUE  = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned CSPIC_PWR_COE      = 7;
    localparam int unsigned CSPIC_PWR_AUTO     = 5;
    localparam int unsigned CSPIC_PWR_VCCEN    = 4;
    localparam int unsigned CSPIC_PWR_VCC_LSB  = 3;
    localparam int unsigned CSPIC_PWR_VPP_LSB  = 0;
    localparam int unsigned CSPIC_CTL_RING     = 7;
    localparam int unsigned CSPIC_CTL_RUN      = 6;
    localparam int unsigned CSPIC_CTL_KIND     = 5;
    localparam int unsigned CSPIC_CTL_ROUTE    = 4;
    localparam int unsigned CSPIC_CTL_SEL_LSB  = 0;

    // Bits kept in storage and bits visible per layout
    localparam logic [7:0]  CSPIC_PWR_STORE    = 8'hBB;
    localparam logic [7:0]  CSPIC_PWR_RD_STD   = 8'hB3;
    localparam logic [7:0]  CSPIC_PWR_RD_ALT   = 8'h9B;
    localparam logic [3:0]  CSPIC_REV_STANDARD = 4'h2;

    // ----------------------------------------------------------------
    // Supply codes
    // ----------------------------------------------------------------
    localparam logic [1:0]  CSPIC_VPP_NONE     = 2'h0;
    localparam logic [1:0]  CSPIC_VPP_VCC      = 2'h1;
    localparam logic [1:0]  CSPIC_VPP_12V      = 2'h2;
    localparam logic [1:0]  CSPIC_VCC_5V_CODE  = 2'h2;
    localparam logic [1:0]  CSPIC_VCC_3V_CODE  = 2'h3;
    localparam logic [1:0]  CSPIC_LVL_OFF      = 2'h0;
    localparam logic [1:0]  CSPIC_LVL_5V       = 2'h1;
    localparam logic [1:0]  CSPIC_LVL_3V       = 2'h2;
    localparam logic [3:0]  CSPIC_IRQ_NONE     = 4'h0;
    localparam logic [3:0]  CSPIC_IRQ_SMI      = 4'h2;

    // Cycles from a taken read request to its registered read data
    localparam int unsigned CSPIC_READ_LATENCY = 1;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } cspic_bus_req_type;

    typedef struct packed {
        logic       card_output_enable;
        logic       auto_sw;
        logic       vcc_on;
        logic [1:0] vcc_level;
        logic [1:0] vpp_level;
    } cspic_supply_type;

    typedef struct packed {
        logic       ring_en;
        logic       card_run;
        logic       io_card;
        logic       csc_pci;
        logic [3:0] irq_sel;
    } cspic_ctrl_type;

endpackage

/* hdl/cspic_sock_regs.sv */
`timescale 1ns/100ps
module cspic_sock_regs
    import cspic_pkg::*;
(
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    input  wire logic             wr_power_in,
    input  wire logic             wr_ctrl_in,
    input  wire logic [7:0]       wdata_in,
    input  wire logic             std_mode_in,
    input  wire logic             sys_power_sel_in,
    input  wire logic             card_detect_in,
    output logic      [7:0]       power_rd_out,
    output logic      [7:0]       ctrl_rd_out,
    output cspic_supply_type      supply_out,
    output cspic_ctrl_type        ctrl_out
);

    logic [7:0] power_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] power_next;
    logic [7:0] ctrl_next;

    // Read-only bits are never stored, so they cannot leak back
    assign power_next = wr_power_in ? (wdata_in & CSPIC_PWR_STORE) : power_reg;
    assign ctrl_next  = wr_ctrl_in  ? wdata_in : ctrl_reg;

    // Register storage
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            power_reg <= CSPIC_RESET_VALUE;
            ctrl_reg  <= CSPIC_RESET_VALUE;
        end else begin
            power_reg <= power_next;
            ctrl_reg  <= ctrl_next;
        end
    end

    // Readback masks follow the active layout
    assign power_rd_out = power_reg & (std_mode_in ? CSPIC_PWR_RD_STD : CSPIC_PWR_RD_ALT);
    assign ctrl_rd_out  = ctrl_reg;

    // Supply decode
    wire [1:0] vcc_code = power_reg[CSPIC_PWR_VCC_LSB +: 2];
    wire [1:0] vpp_code = power_reg[CSPIC_PWR_VPP_LSB +: 2];
    wire       auto_sw  = std_mode_in & power_reg[CSPIC_PWR_AUTO];
    wire       std_req  = power_reg[CSPIC_PWR_VCCEN];
    wire       alt_req  = (vcc_code == CSPIC_VCC_5V_CODE) || (vcc_code == CSPIC_VCC_3V_CODE);
    wire       vcc_req  = std_mode_in ? std_req : alt_req;
    // Automatic switching holds power off while no card is seated
    wire       vcc_on   = vcc_req & (~auto_sw | card_detect_in);
    wire [1:0] std_lvl  = sys_power_sel_in ? CSPIC_LVL_3V : CSPIC_LVL_5V;
    wire [1:0] alt_lvl  = (vcc_code == CSPIC_VCC_3V_CODE) ? CSPIC_LVL_3V : CSPIC_LVL_5V;
    wire       vpp_ok   = (vpp_code == CSPIC_VPP_VCC) || (vpp_code == CSPIC_VPP_12V);

    assign supply_out.card_output_enable       = power_reg[CSPIC_PWR_COE];
    assign supply_out.auto_sw   = auto_sw;
    assign supply_out.vcc_on    = vcc_on;
    assign supply_out.vcc_level = vcc_on ? (std_mode_in ? std_lvl : alt_lvl) : CSPIC_LVL_OFF;
    assign supply_out.vpp_level = (vcc_on && vpp_ok) ? vpp_code : CSPIC_VPP_NONE;

    // Control fields
    assign ctrl_out.ring_en  = ctrl_reg[CSPIC_CTL_RING];
    assign ctrl_out.card_run = ctrl_reg[CSPIC_CTL_RUN];
    assign ctrl_out.io_card  = ctrl_reg[CSPIC_CTL_KIND];
    assign ctrl_out.csc_pci  = ctrl_reg[CSPIC_CTL_ROUTE];
    assign ctrl_out.irq_sel  = ctrl_reg[CSPIC_CTL_SEL_LSB +: 4];

endmodule

/* hdl/cspic_irq_route.sv */
`timescale 1ns/100ps
module cspic_irq_route
    import cspic_pkg::*;
(
    input  wire cspic_ctrl_type   ctrl_in,
    input  wire logic [3:0]       csc_line_sel_in,
    input  wire logic             card_irq_in,
    input  wire logic             csc_irq_in,
    output logic                  pci_irq_out,
    output logic      [15:0]      isa_irq_out,
    output logic                  smi_out
);

    // Code to one-hot legacy line; the none and SMI codes map to no line
    function automatic logic [15:0] line_decode(input logic [3:0] sel);
        logic [15:0] hot;
        hot = 16'h0001 << sel;
        if (sel == CSPIC_IRQ_NONE || sel == CSPIC_IRQ_SMI) begin
            hot = 16'h0000;
        end
        return hot;
    endfunction

    // A zero functional select also steers status change to PCI
    wire       csc_to_pci = ctrl_in.csc_pci | (ctrl_in.irq_sel == CSPIC_IRQ_NONE);
    wire       func_irq   = card_irq_in & ctrl_in.io_card;
    wire [15:0] func_lines = func_irq ? line_decode(ctrl_in.irq_sel) : 16'h0000;
    wire [15:0] csc_lines  = (csc_irq_in & ~csc_to_pci) ? line_decode(csc_line_sel_in)
                                                       : 16'h0000;

    assign pci_irq_out = csc_irq_in & csc_to_pci;
    assign isa_irq_out = func_lines | csc_lines;
    assign smi_out     = func_irq & (ctrl_in.irq_sel == CSPIC_IRQ_SMI);

endmodule

/* test/cspic_card_model.sv */
`timescale 1ns/100ps
module cspic_card_model
    import cspic_pkg::*;
(
    input  wire logic mclk_in,
    input  wire logic card_reset_in,
    input  wire logic seated_in,
    input  wire logic irq_req_in,
    output logic      card_detect_out,
    output logic      irq_out
);
    // A card held in reset keeps its interrupt low, so routing is seen only after release
    always_ff @(posedge mclk_in) begin
        card_detect_out <= seated_in;
        irq_out         <= irq_req_in & ~card_reset_in;
    end
endmodule

/* test/test_cspic_top.sv */
`timescale 1ns/100ps
module test_cspic_top import cspic_pkg::*;;
    logic              mclk_in = 1'b0;
    logic              rst_n_in = 1'b0;
    cspic_bus_req_type req = '0;
    logic [3:0]        rev = 4'h2;
    logic [1:0]        psel = '0, ring = '0, cscirq = '0;
    logic [7:0]        cscsel = '0, d;
    logic              seated = 1'b1, irq_req = 1'b0, det, cirq, pci, smi, rdv;
    logic [1:0]        card_output_enable, vcc_en, pstat, crst, ring_o, kind, auto_o, roe_n;
    logic [3:0]        vcc_lvl, vpp;
    logic [15:0]       isa;
    int                err_total = 0, num_checks = 0;

    cspic_top i_cspic_top (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .bus_req_in(req),
        .compat_revision_field_in(rev), .system_power_select_in(psel),
        .card_detect_in({1'b1, det}), .battery_detect_ring_in(ring),
        .card_irq_in({1'b0, cirq}), .status_change_irq_in(cscirq),
        .status_change_line_select_in(cscsel), .rd_data_out(d), .rd_valid_out(rdv),
        .card_output_enable_out(card_output_enable), .auto_power_switch_en_out(auto_o),
        .socket_vcc_enable_out(vcc_en), .vcc_level_out(vcc_lvl), .vpp_level_out(vpp),
        .socket_power_status_out(pstat), .card_reset_out(crst), .card_reset_oe_n_out(roe_n),
        .ring_indicate_out(ring_o), .card_kind_select_out(kind), .pci_irq_out(pci),
        .isa_irq_out(isa), .smi_out(smi));
    cspic_card_model i_cspic_card_model (.mclk_in(mclk_in), .card_reset_in(crst[0]),
        .seated_in(seated), .irq_req_in(irq_req), .card_detect_out(det), .irq_out(cirq));

    // ----------------------------------------------------------------
    // Clock, access tasks and checking
    // ----------------------------------------------------------------
    initial forever #5 mclk_in = ~mclk_in;
    // Outputs are registered twice after a write, so three edges leave margin
    task automatic pause();
        repeat (3) @(posedge mclk_in);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge mclk_in) req <= {2'b10, a, v};
        @(posedge mclk_in) req <= '0;
        pause();
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge mclk_in) req <= {2'b01, a, 8'h00};
        @(posedge mclk_in) req <= '0;
        #1;
        chk({16'h0000, rdv}, 17'h0_0001);
        chk({9'h000, d}, {9'h000, e});
    endtask
    task automatic chk(input logic [16:0] s, input logic [16:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("errors=%0d checks=%0d", err_total, num_checks);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Whole run is under two hundred cycles; a hang is cut well beyond that
    initial begin
        #100us;
        err_total++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        rd(12'h002, 8'h00);
        chk({13'h0, crst, roe_n}, 17'h0_000F);
        wr(12'h802, 8'hFF);
        rd(12'h002, 8'hB3);
        chk({14'h0, card_output_enable[0], vcc_en[0], pstat[0]}, 17'h0_0007);
        chk({15'h0, auto_o[0], roe_n[0]}, 17'h0_0002);
        chk({15'h0, vpp[1:0]}, 17'h0_0000);
        @(posedge mclk_in) seated <= 1'b0;
        pause();
        chk({16'h0, vcc_en[0]}, 17'h0_0000);
        @(posedge mclk_in) seated <= 1'b1;
        psel <= 2'b01;
        wr(12'h002, 8'h12);
        chk({13'h0, vcc_lvl[1:0], vpp[1:0]}, {13'h0, CSPIC_LVL_3V, CSPIC_VPP_12V});
        wr(12'h002, 8'h02);
        chk({15'h0, pstat[0], vpp[0]}, 17'h0_0000);
        wr(12'h042, 8'h81);
        rd(12'h842, 8'h81);
        rd(12'h002, 8'h02);
        chk({15'h0, card_output_enable}, 17'h0_0002);
        @(posedge mclk_in) rev <= 4'h0;
        wr(12'h002, 8'hFF);
        rd(12'h002, 8'h9B);
        chk({15'h0, auto_o[0], roe_n[0]}, 17'h0_0000);
        // Every Vcc request code, reserved ones included
        for (int v = 0; v < 4; v++) begin
            wr(12'h002, {3'b000, v[1:0], 3'b001});
            chk({13'h0, vcc_lvl[1:0], vpp[1:0]}, (v == 2) ? 17'h5 : (v == 3) ? 17'h9 : 17'h0);
        end
        @(posedge mclk_in) rev <= 4'h2;
        ring <= 2'b01;
        wr(12'h003, 8'hE0);
        rd(12'h003, 8'hE0);
        chk({14'h0, crst[0], kind[0], ring_o[0]}, 17'h0_0003);
        wr(12'h003, 8'h60);
        chk({16'h0, ring_o[0]}, 17'h0_0000);
        @(posedge mclk_in) irq_req <= 1'b1;
        // Every functional line select code with the card interrupt raised
        for (int n = 0; n < 16; n++) begin
            wr(12'h003, {4'h6, n[3:0]});
            chk({smi, isa}, (n == 2) ? 17'h1_0000 : (n == 0) ? 17'h0 : 17'(1 << n));
        end
        @(posedge mclk_in) irq_req <= 1'b0;
        cscirq <= 2'b01;
        cscsel <= 8'h05;
        wr(12'h003, 8'h75);
        chk({16'h0, pci}, 17'h0_0001);
        wr(12'h003, 8'h65);
        chk({16'h0, pci}, 17'h0_0000);
        chk({1'b0, isa}, 17'h0_0020);
        wr(12'h003, 8'h60);
        chk({16'h0, pci}, 17'h0_0001);
        // Mid-run reset must clear both sockets and hold the card in reset
        @(posedge mclk_in) rst_n_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        rd(12'h842, 8'h00);
        chk({13'h0, crst, roe_n}, 17'h0_000F);
        end_of_test();
    end
endmodule
